//--- src/swtcm_clkmon.sv
// Clock-frequency monitor with release delay
`timescale 1ns/1ps
module swtcm_clkmon #(
   parameter int unsigned GAP_CYC = swtcm_pkg::CM_GAP_CYC
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic ce_i,
   // Control
   input  wire logic tc_tick_i,
   input  wire logic enable_i,
   // Fault drive
   output logic      drive_o
);
   localparam int unsigned GW = $clog2(GAP_CYC + 1);
   localparam logic [GW-1:0] GAP_MAX = GW'(GAP_CYC);
   localparam logic [swtcm_pkg::HOLD_W-1:0] HOLD_LAST =
      swtcm_pkg::HOLD_W'(swtcm_pkg::HOLD_TC - 1);

   logic [GW-1:0]                  gap;
   logic [GW-1:0]                  next_gap;
   logic [swtcm_pkg::HOLD_W-1:0]   hold;
   logic [swtcm_pkg::HOLD_W-1:0]   next_hold;
   logic                           next_drive;
   logic                           slow;

   // ==========================================================
   // Gap measurement and drive
   always_comb begin
      next_gap   = gap;
      next_hold  = hold;
      next_drive = drive_o;
      // Counter saturates so a dead oscillator stays flagged
      if (tc_tick_i) begin
         next_gap = '0;
      end else if (gap != GAP_MAX) begin
         next_gap = gap + GW'(1);
      end
      slow = (gap == GAP_MAX);
      if (!enable_i) begin
         next_drive = 1'b0;
         next_hold  = '0;
      end else if (slow) begin
         next_drive = 1'b1;
         next_hold  = '0;
      end else if (drive_o && tc_tick_i) begin
         if (hold == HOLD_LAST) begin
            next_drive = 1'b0;
            next_hold  = '0;
         end else begin
            next_hold = hold + swtcm_pkg::HOLD_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap     <= '0;
         hold    <= '0;
         drive_o <= 1'b0;
      end else if (ce_i) begin
         gap     <= next_gap;
         hold    <= next_hold;
         drive_o <= next_drive;
      end
   end
endmodule : swtcm_clkmon

//--- src/swtcm_pkg.sv
// Shared constants for the service window timer and clock monitor
package swtcm_pkg;
   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 25;
   // Slowest instruction-cycle gap accepted before a clock error
   localparam int unsigned CM_GAP_NS     = 1_000_000;
   localparam int unsigned CM_GAP_CYC    = CM_GAP_NS / CLK_PERIOD_NS;
   localparam int unsigned LOWER_TC      = 2048;
   localparam int unsigned UPPER_BASE_TC = 8192;
   localparam int unsigned HOLD_TC       = 24;
   localparam int unsigned WIN_W         = 17;
   localparam int unsigned HOLD_W        = 6;
   // ==========================================================
   // Service register layout
   localparam int unsigned SEL_MSB   = 7;
   localparam int unsigned SEL_LSB   = 6;
   localparam int unsigned KEY_MSB   = 5;
   localparam int unsigned KEY_LSB   = 1;
   localparam int unsigned CMEN_BIT  = 0;
   localparam logic [4:0] KEY_VALUE  = 5'h0C;
   localparam logic [1:0] SEL_RESET  = 2'h3;
   localparam logic       CMEN_RESET = 1'b1;
   // ==========================================================
   // Idle timer
   localparam int unsigned IDLE_W       = 16;
   localparam int unsigned IDLE_TOG_BIT = 12;
   // ==========================================================
   // Window timer states
   typedef enum logic [1:0] {
      WD_RUN,
      WD_DRIVE,
      WD_HOLD,
      WD_WAITHI
   } swtcm_wd_state_t;
endpackage : swtcm_pkg

//--- src/swtcm_top.sv
// Service window timer with clock monitor and shared fault pin
// Behaviour
// - Service under 2048 cycles since restart errs
// - Bits 7:6 pick 8k/16k/32k/64k upper limit
// - Bits 5:1 must hold key 01100
// - Bit 0 enables the clock monitor
// - Reset holds detectors off, then 64k, monitor on
// - First keyed write locks settings, counts service
// - Later writes compare window and key fields
// - No service before upper limit raises fault
// - Initial service allowed anywhere in window
// - Fault pin active low, released otherwise
// - Hold low 16-32 cycles after pin low
// - Window restarts when pin returns high
// - Writes ignored while fault is asserted
// - Pin low at power-up runs timeout sequence
// - Monitor holds pin low while clock slow
// - Above 10 kHz passes, below 10 Hz flagged
// - Key field reads back as zeros
// - Timer paused in halt/idle, monitor keeps running
// - Halt exit resumes or restarts per oscillator option
// - Idle exit performs an internal service
// - Idle timer bit toggle sets pending flag
`timescale 1ns/1ps
module swtcm_top #(
   parameter int unsigned CM_GAP_CYC = swtcm_pkg::CM_GAP_CYC
) (
   // Clock, enable and resets
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       por_resetn_i,
   input  wire logic       ce_i,
   // Instruction-cycle tick
   input  wire logic       tc_tick_i,
   // Service register port
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // Power modes and options
   input  wire logic       halt_i,
   input  wire logic       idle_i,
   input  wire logic       rc_osc_option_i,
   input  wire logic       clock_delay_select_i,
   // Idle timer flag
   input  wire logic       idle_pend_clr_i,
   output logic            idle_timer_pending_flag_o,
   // Fault pin, port G bit 1
   input  wire logic       port_g_bit1_pin_i,
   output logic            port_g_bit1_pin_o,
   output logic            port_g_bit1_pin_oe_o
);
   localparam logic [swtcm_pkg::WIN_W-1:0] LOWER =
      swtcm_pkg::WIN_W'(swtcm_pkg::LOWER_TC);
   localparam logic [swtcm_pkg::HOLD_W-1:0] HOLD_LAST =
      swtcm_pkg::HOLD_W'(swtcm_pkg::HOLD_TC - 1);

   // ==========================================================
   // Upper limit decode
   function automatic logic [swtcm_pkg::WIN_W-1:0] upper_limit(
      input logic [1:0] sel
   );
      upper_limit = swtcm_pkg::WIN_W'(swtcm_pkg::UPPER_BASE_TC) << sel;
   endfunction : upper_limit

   // ==========================================================
   // Reset synchroniser
   logic rst_s1;
   logic rst_n;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // ==========================================================
   // Clock monitor
   logic cm_en;
   logic cm_drive;

   swtcm_clkmon #(
      .GAP_CYC (CM_GAP_CYC)
   ) u_clkmon (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n),
      .ce_i      (ce_i),
      .tc_tick_i (tc_tick_i),
      .enable_i  (cm_en),
      .drive_o   (cm_drive)
   );

   // ==========================================================
   // Window timer state
   swtcm_pkg::swtcm_wd_state_t      state;
   swtcm_pkg::swtcm_wd_state_t      next_state;
   logic [swtcm_pkg::WIN_W-1:0]     win;
   logic [swtcm_pkg::WIN_W-1:0]     next_win;
   logic [swtcm_pkg::HOLD_W-1:0]    hold;
   logic [swtcm_pkg::HOLD_W-1:0]    next_hold;
   logic [1:0]                      sel;
   logic [1:0]                      next_sel;
   logic                            next_cm_en;
   logic                            locked;
   logic                            next_locked;
   logic                            boot;
   logic                            halt_q;
   logic                            idle_q;
   logic                            pend;
   logic                            next_pend;
   logic [7:0]                      next_rdata;
   logic                            next_oe;
   logic                            wr_ok;
   logic                            key_ok;
   logic                            win_ok;
   logic                            halt_exit;
   logic                            idle_exit;
   logic                            fault;
   logic                            restart;
   logic                            tog;

   assign halt_exit = halt_q && !halt_i;
   assign idle_exit = idle_q && !idle_i;
   assign key_ok    = reg_wdata_i[swtcm_pkg::KEY_MSB:swtcm_pkg::KEY_LSB]
                      == swtcm_pkg::KEY_VALUE;
   assign win_ok    = (reg_wdata_i[swtcm_pkg::SEL_MSB:swtcm_pkg::SEL_LSB] == sel)
                      && (reg_wdata_i[swtcm_pkg::CMEN_BIT] == cm_en);
   // A write during any active fault drive is dropped
   assign wr_ok     = reg_wr_i && (state == swtcm_pkg::WD_RUN) && !cm_drive;

   always_comb begin
      next_state  = state;
      next_win    = win;
      next_hold   = hold;
      next_sel    = sel;
      next_cm_en  = cm_en;
      next_locked = locked;
      fault       = 1'b0;
      restart     = 1'b0;
      case (state)
         swtcm_pkg::WD_RUN: begin
            if (boot && !port_g_bit1_pin_i) begin
               fault = 1'b1;
            end else if (wr_ok) begin
               if (!locked) begin
                  // Initial service is free of the early check
                  if (key_ok) begin
                     next_locked = 1'b1;
                     next_sel    = reg_wdata_i[swtcm_pkg::SEL_MSB:swtcm_pkg::SEL_LSB];
                     next_cm_en  = reg_wdata_i[swtcm_pkg::CMEN_BIT];
                     restart     = 1'b1;
                  end else begin
                     fault = 1'b1;
                  end
               end else if (!key_ok || !win_ok) begin
                  fault = 1'b1;
               end else if (win < LOWER) begin
                  fault = 1'b1;
               end else begin
                  restart = 1'b1;
               end
            end else if (idle_exit) begin
               restart = 1'b1;
            end else if (halt_exit && !(rc_osc_option_i && !clock_delay_select_i)) begin
               restart = 1'b1;
            end else if (tc_tick_i && !halt_i && !idle_i) begin
               if (win + swtcm_pkg::WIN_W'(1) >= upper_limit(sel)) begin
                  fault = 1'b1;
               end else begin
                  next_win = win + swtcm_pkg::WIN_W'(1);
               end
            end
            if (fault) begin
               next_state = swtcm_pkg::WD_DRIVE;
            end
            if (restart) begin
               next_win = '0;
            end
         end
         swtcm_pkg::WD_DRIVE: begin
            // Delay counts only once the pin is seen low
            if (!port_g_bit1_pin_i) begin
               next_state = swtcm_pkg::WD_HOLD;
               next_hold  = '0;
            end
         end
         swtcm_pkg::WD_HOLD: begin
            if (tc_tick_i) begin
               if (hold == HOLD_LAST) begin
                  next_state = swtcm_pkg::WD_WAITHI;
               end else begin
                  next_hold = hold + swtcm_pkg::HOLD_W'(1);
               end
            end
         end
         swtcm_pkg::WD_WAITHI: begin
            if (port_g_bit1_pin_i) begin
               next_state = swtcm_pkg::WD_RUN;
               next_win   = '0;
            end
         end
         default: begin
            next_state = swtcm_pkg::WD_RUN;
         end
      endcase
   end

   always_comb begin
      next_oe = (next_state == swtcm_pkg::WD_DRIVE)
                || (next_state == swtcm_pkg::WD_HOLD)
                || cm_drive;
      next_rdata = {next_sel, 5'h00, next_cm_en};
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state                <= swtcm_pkg::WD_RUN;
         win                  <= '0;
         hold                 <= '0;
         sel                  <= swtcm_pkg::SEL_RESET;
         cm_en                <= swtcm_pkg::CMEN_RESET;
         locked               <= 1'b0;
         boot                 <= 1'b1;
         halt_q               <= 1'b0;
         idle_q               <= 1'b0;
         reg_rdata_o          <= {swtcm_pkg::SEL_RESET, 5'h00, swtcm_pkg::CMEN_RESET};
         port_g_bit1_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         state                <= next_state;
         win                  <= next_win;
         hold                 <= next_hold;
         sel                  <= next_sel;
         cm_en                <= next_cm_en;
         locked               <= next_locked;
         boot                 <= 1'b0;
         halt_q               <= halt_i;
         idle_q               <= idle_i;
         reg_rdata_o          <= next_rdata;
         port_g_bit1_pin_oe_o <= next_oe;
      end
   end

   // Pin is only ever pulled low, never driven high
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         port_g_bit1_pin_o <= 1'b0;
      end else begin
         port_g_bit1_pin_o <= 1'b0;
      end
   end

   // ==========================================================
   // Idle timer, kept across device reset
   logic [swtcm_pkg::IDLE_W-1:0] idle_cnt;
   logic [swtcm_pkg::IDLE_W-1:0] next_idle_cnt;

   always_comb begin
      next_idle_cnt = idle_cnt;
      if (tc_tick_i) begin
         next_idle_cnt = idle_cnt + swtcm_pkg::IDLE_W'(1);
      end
      tog = next_idle_cnt[swtcm_pkg::IDLE_TOG_BIT]
            != idle_cnt[swtcm_pkg::IDLE_TOG_BIT];
      // Set wins over a clear in the same cycle
      next_pend = tog || (pend && !idle_pend_clr_i);
   end

   // Only power-on clears it: device reset leaves it running
   always_ff @(posedge clk_i or negedge por_resetn_i) begin
      if (!por_resetn_i) begin
         idle_cnt <= '0;
      end else if (ce_i) begin
         idle_cnt <= next_idle_cnt;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pend <= 1'b0;
      end else if (ce_i) begin
         pend <= next_pend;
      end
   end

   assign idle_timer_pending_flag_o = pend;
endmodule : swtcm_top

//--- verif/swtcm_assertions.sv
// Port checker for the service window timer and clock monitor
`timescale 1ns/1ps
module swtcm_checker #(
   parameter int unsigned CM_GAP_CYC = swtcm_pkg::CM_GAP_CYC
) (
   // Clock, reset and control
   input wire logic       clk_i,
   input wire logic       resetn_i,
   input wire logic       ce_i,
   input wire logic       tc_tick_i,
   input wire logic       halt_i,
   input wire logic       idle_i,
   // Register port and pin
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       port_g_bit1_pin_i,
   input wire logic       port_g_bit1_pin_o,
   input wire logic       port_g_bit1_pin_oe_o
);
   // ==========
   // Tick counters
   logic        oe;
   logic [31:0] hold_cnt, gap_cnt, win_cnt;
   logic [31:0] next_hold_cnt, next_gap_cnt, next_win_cnt;
   assign oe = port_g_bit1_pin_oe_o;
   always_comb begin
      next_hold_cnt = (oe && !port_g_bit1_pin_i) ? hold_cnt + {31'h0, tc_tick_i} : '0;
      next_gap_cnt  = tc_tick_i ? '0 : gap_cnt + 32'h0000_0001;
      // Any event that may restart the window clears it
      next_win_cnt  = (reg_wr_i || oe || !port_g_bit1_pin_i || halt_i || idle_i) ? '0
                      : win_cnt + {31'h0, tc_tick_i};
   end
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hold_cnt <= '0;
         gap_cnt  <= '0;
         win_cnt  <= '0;
      end else begin
         hold_cnt <= next_hold_cnt;
         gap_cnt  <= next_gap_cnt;
         win_cnt  <= next_win_cnt;
      end
   end
   // ==========
   // Properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   pin_low_a: assert property (port_g_bit1_pin_o == 1'b0)
      else $error("fault pin data not low");
   reset_quiet_a: assert property (disable iff (1'b0) !resetn_i |-> !oe)
      else $error("fault pin driven in reset");
   key_hidden_a: assert property (reg_rdata_o[5:1] == 5'h00)
      else $error("key field visible on read");
   hold_time_a: assert property ($fell(oe) |-> hold_cnt >= 16 && hold_cnt <= 32)
      else $error("release delay out of range");
   read_cause_a: assert property (
      !$stable(reg_rdata_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
      else $error("read data changed without write");
   fault_write_a: assert property (reg_wr_i && oe |=> $stable(reg_rdata_o) [*2])
      else $error("write during fault took effect");
   drive_hold_a: assert property (oe && port_g_bit1_pin_i |=> oe)
      else $error("released before pin seen low");
   bad_key_a: assert property (
      reg_wr_i && ce_i && !oe && port_g_bit1_pin_i && $past(port_g_bit1_pin_i)
      && reg_wdata_i[5:1] != 5'h0C |-> ##[1:2] oe)
      else $error("bad key did not fault");
   window_bound_a: assert property (win_cnt <= 32'h0001_0001)
      else $error("window overran without fault");
   clock_stop_a: assert property (reg_rdata_o[0] && gap_cnt == CM_GAP_CYC + 8 |-> oe)
      else $error("stopped clock not flagged");
   cover property ($fell(oe));
   cover property (reg_wr_i && !oe);
   cover property (gap_cnt == CM_GAP_CYC);
endmodule : swtcm_checker

bind swtcm_top swtcm_checker #(.CM_GAP_CYC(CM_GAP_CYC)) swtcm_checker_inst (
   .clk_i, .resetn_i, .ce_i, .tc_tick_i, .halt_i, .idle_i, .reg_wr_i, .reg_wdata_i,
   .reg_rdata_o, .port_g_bit1_pin_i, .port_g_bit1_pin_o, .port_g_bit1_pin_oe_o);

//--- verif/swtcm_pin_model.sv
// Pull-up and external supervisor on the fault pin
`timescale 1ns/1ps
module swtcm_pin_model (
   // From the block
   input  wire logic pin_o_i,
   input  wire logic pin_oe_i,
   // External supervisor holding the line low
   input  wire logic ext_low_i,
   // Resolved level
   output logic      pin_level_o
);
   // Open drain: pull-up wins unless someone pulls low
   assign pin_level_o = !((pin_oe_i && !pin_o_i) || ext_low_i);
endmodule : swtcm_pin_model

//--- verif/swtcm_tb.sv
// Self-checking bench for the service window timer
`timescale 1ns/1ps
module swtcm_tb;
   localparam int unsigned GAP = 200;
   // ==========
   // Signals
   logic       clk_i = 1'b0;
   logic       resetn_i = 1'b0;
   logic       por_resetn_i = 1'b0;
   logic       tc_tick_i = 1'b0;
   logic       tick_en = 1'b1;
   logic       reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic       idle_i = 1'b0;
   logic       halt_i = 1'b0;
   logic       rc_osc_option_i = 1'b0;
   logic       clock_delay_select_i = 1'b0;
   logic       idle_pend_clr_i = 1'b0;
   logic       ext_low = 1'b0;
   logic [7:0] reg_rdata_o;
   logic       flag, pin, pin_o, oe;
   int         fail_count = 0;
   int         comparisons = 0;
   int         n;
   initial forever #12.5 clk_i = ~clk_i;
   // One instruction cycle every two clocks
   always @(negedge clk_i) tc_tick_i <= tick_en && !tc_tick_i;
   swtcm_top #(.CM_GAP_CYC(GAP)) swtcm_top_inst (
      .clk_i, .resetn_i, .por_resetn_i, .ce_i(1'b1), .tc_tick_i, .reg_wr_i, .reg_wdata_i,
      .reg_rdata_o, .halt_i, .idle_i, .rc_osc_option_i,
      .clock_delay_select_i, .idle_pend_clr_i, .idle_timer_pending_flag_o(flag),
      .port_g_bit1_pin_i(pin), .port_g_bit1_pin_o(pin_o), .port_g_bit1_pin_oe_o(oe));
   swtcm_pin_model swtcm_pin_model_inst (
      .pin_o_i(pin_o), .pin_oe_i(oe), .ext_low_i(ext_low), .pin_level_o(pin));
   // ==========
   // Tasks
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic clocks(input int c);
      repeat (c) @(negedge clk_i);
   endtask : clocks
   task automatic rst(input logic low);
      ext_low = low;
      resetn_i = 1'b0;
      clocks(5);
      resetn_i = 1'b1;
      por_resetn_i = 1'b1;
      clocks(3);
      ext_low = 1'b0;
   endtask : rst
   task automatic wr(input logic [7:0] d);
      @(negedge clk_i);
      reg_wr_i = 1'b1;
      reg_wdata_i = d;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
      clocks(3);
   endtask : wr
   task automatic wait_oe(input logic lvl, input int lim);
      n = 0;
      while (oe !== lvl && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      if (oe !== lvl) begin
         chk(oe, lvl);
         results();
      end
   endtask : wait_oe
   // Fault seen, then released 16 to 32 ticks later
   task automatic fault_seq;
      wait_oe(1'b1, 20);
      wait_oe(1'b0, 200);
      chk(n >= 32 && n <= 66, 1'b1);
      clocks(4);
   endtask : fault_seq
   // ==========
   // Sequence
   initial begin
      rst(1'b0);
      chk(reg_rdata_o, 8'hC1);
      chk(oe, 1'b0);
      wr(8'h18);
      chk(oe, 1'b0);
      chk(reg_rdata_o, 8'h00);
      tick_en = 1'b0;
      clocks(3 * GAP);
      chk(oe, 1'b0);
      tick_en = 1'b1;
      clocks(4200);
      wr(8'h18);
      chk(oe, 1'b0);
      clocks(4200);
      wr(8'h58);
      wr(8'hD9);
      fault_seq;
      chk(reg_rdata_o, 8'h00);
      wr(8'h18);
      fault_seq;
      clocks(4200);
      wr(8'h1A);
      fault_seq;
      clocks(2 * 8192 - 200);
      chk(oe, 1'b0);
      wait_oe(1'b1, 400);
      fault_seq;
      clocks(4200);
      idle_i = 1'b1;
      clocks(200);
      idle_i = 1'b0;
      clocks(20);
      wr(8'h18);
      fault_seq;
      // Halt longer than the window: paused, then restarted on exit
      clocks(4200);
      halt_i = 1'b1;
      clocks(17000);
      chk(oe, 1'b0);
      halt_i = 1'b0;
      clocks(20);
      wr(8'h18);
      fault_seq;
      // RC option with delay bit clear resumes the count
      rc_osc_option_i = 1'b1;
      clocks(4200);
      halt_i = 1'b1;
      clocks(200);
      halt_i = 1'b0;
      clocks(20);
      wr(8'h18);
      chk(oe, 1'b0);
      idle_pend_clr_i = 1'b1;
      clocks(1);
      idle_pend_clr_i = 1'b0;
      chk(flag, 1'b0);
      clocks(8200);
      chk(flag, 1'b1);
      rst(1'b0);
      tick_en = 1'b0;
      wait_oe(1'b1, 2 * GAP);
      tick_en = 1'b1;
      wait_oe(1'b0, 200);
      chk(n >= 32 && n <= 66, 1'b1);
      rst(1'b1);
      fault_seq;
      chk(pin, 1'b1);
      results();
   end
endmodule : swtcm_tb
